/* File: design/rco_pkg.sv */
package rco_pkg;
    // ----------------------------------------
    // register indices (byte address divided by four)
    // ----------------------------------------
    localparam logic [3:0] IDX_PCL = 4'h2;
    localparam logic [3:0] IDX_STATUS = 4'h3;
    localparam logic [3:0] IDX_FSR = 4'h4;
    localparam logic [3:0] IDX_TRIM = 4'h5;
    localparam logic [3:0] IDX_CAUSE = 4'h8; // cause code readback
    localparam logic [3:0] IDX_CTRL = 4'h9; // sleep control, w readback
    localparam logic [3:0] IDX_CALIB = 4'ha; // calibration word readback
    // ----------------------------------------
    // config word fields
    // ----------------------------------------
    localparam int CFG_W = 12;
    localparam int CFG_RST_BIT = 4;
    localparam int CFG_CP_BIT = 3;
    localparam int CFG_WDT_BIT = 2;
    localparam logic [11:0] CFG_MASK = 12'h01c;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] PCL_RST = 8'hff;
    localparam logic [7:0] TRIM_POR = 8'hfe;
    localparam logic [7:0] OPT_RST = 8'hff;
    localparam logic [3:0] DIR_RST = 4'hf;
    localparam logic [7:0] FSR_SET = 8'he0;
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam int ST_PIN = 7;
    localparam int ST_CMP = 6;
    localparam int ST_TO = 4;
    localparam int ST_PD = 3;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int OSC_HZ = 4_000_000; // nominal internal oscillator
    localparam int DLY_POR_MS = 18;
    localparam int DLY_RST_US = 10;
    localparam int DLY_POR_CYC = DLY_POR_MS * (CLK_HZ / 1000);
    localparam int DLY_RST_CYC = DLY_RST_US * (CLK_HZ / 1_000_000);
    // ----------------------------------------
    // reset causes
    // ----------------------------------------
    typedef enum logic [2:0] {
        RCO_C_POR, RCO_C_EXT_RUN, RCO_C_EXT_SLP, RCO_C_WDT_RUN,
        RCO_C_WDT_SLP, RCO_C_PIN_WAKE, RCO_C_CMP_WAKE
    } rco_cause_e;
    typedef enum logic [1:0] {RCO_S_HOLD, RCO_S_VECTOR, RCO_S_RUN, RCO_S_SLEEP} rco_state_e;
endpackage

/* File: design/rco_reset_config.sv */
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module rco_reset_config #(
    parameter int POR_CYC = rco_pkg::DLY_POR_CYC,
    parameter int RST_CYC = rco_pkg::DLY_RST_CYC
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [11:0] cfg_word_in, // fuse array contents
    input wire logic [11:0] calib_word_in, // last program location
    input wire logic shared_input_pin,
    input wire logic pin_change,
    input wire logic cmp_change,
    input wire logic watchdog_timeout,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic core_reset,
    output logic [8:0] prog_counter,
    output logic [7:0] work_reg,
    output logic [7:0] osc_trim_reg,
    output logic [7:0] option_reg,
    output logic [3:0] port_direction,
    output logic watchdog_enable_cfg,
    output logic code_protect_sel,
    output logic ext_reset_pin_select,
    output logic [2:0] reset_cause,
    output logic sleeping
);
    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [3:0] s1_r, s2_r, s1_nxt, s2_nxt;
    // two flops per input; first stage read only by second
    always_comb begin
        s1_nxt = {shared_input_pin, pin_change, cmp_change, watchdog_timeout};
        s2_nxt = s1_r;
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // idle levels: pin high, wake and watchdog lines low, so no false event
            s1_r <= 4'h8;
            s2_r <= 4'h8;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end
    // ----------------------------------------
    // config latch
    // ----------------------------------------
    logic [11:0] cfg_r, cfg_nxt;
    logic cfg_ld_r, cfg_ld_nxt;
    // captured once after release; unimplemented bits masked
    always_comb begin
        cfg_ld_nxt = 1'b1;
        cfg_nxt = cfg_ld_r ? cfg_r : (cfg_word_in & rco_pkg::CFG_MASK);
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= 12'h000;
            cfg_ld_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            cfg_ld_r <= cfg_ld_nxt;
        end
    end
    wire logic rst_sel = cfg_r[rco_pkg::CFG_RST_BIT];
    wire logic wdt_en = cfg_r[rco_pkg::CFG_WDT_BIT];
    // pin reset active only when selected, else tied inactive
    wire logic ext_rst = rst_sel & ~s2_r[3];
    // watchdog can only be gated by the fuse
    wire logic wdt_hit = wdt_en & s2_r[0];
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    rco_pkg::rco_state_e st_r, st_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic por_r, por_nxt;
    logic [2:0] cause_r, cause_nxt;
    logic [7:0] status_r, status_nxt, fsr_r, fsr_nxt, trim_r, trim_nxt;
    logic [7:0] pcl_r, pcl_nxt, opt_r, opt_nxt, w_r, w_nxt;
    logic [3:0] dir_r, dir_nxt;
    logic [31:0] prd_r, prd_nxt;
    logic rdy_r, rdy_nxt, err_r, err_nxt;
    // write lands at the edge where the master samples pready high
    wire logic wr_go = psel & penable & pwrite & rdy_r;
    wire logic [3:0] idx = paddr[5:2];
    // state, delay timer, reset-cause and register effects
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        por_nxt = por_r;
        cause_nxt = cause_r;
        status_nxt = status_r;
        fsr_nxt = fsr_r;
        trim_nxt = trim_r;
        pcl_nxt = pcl_r;
        opt_nxt = opt_r;
        w_nxt = w_r;
        dir_nxt = dir_r;
        unique case (st_r)
            rco_pkg::RCO_S_HOLD: begin
                // timer held at zero while the pin holds reset
                if (ext_rst) begin
                    cnt_nxt = 32'h0;
                end else if (cnt_r >= (por_r ? 32'(POR_CYC) : 32'(RST_CYC)) - 32'h1) begin
                    st_nxt = rco_pkg::RCO_S_VECTOR;
                    por_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r + 32'h1;
                end
            end
            rco_pkg::RCO_S_VECTOR: begin
                // literal load from top of memory, then wrap
                w_nxt = calib_word_in[7:0];
                pcl_nxt = 8'h00;
                st_nxt = rco_pkg::RCO_S_RUN;
            end
            rco_pkg::RCO_S_RUN: begin
                if (ext_rst || wdt_hit) begin
                    st_nxt = rco_pkg::RCO_S_HOLD;
                    cnt_nxt = 32'h0;
                    pcl_nxt = rco_pkg::PCL_RST;
                    opt_nxt = rco_pkg::OPT_RST;
                    dir_nxt = rco_pkg::DIR_RST;
                    fsr_nxt = fsr_r | rco_pkg::FSR_SET;
                    status_nxt[7:5] = 3'h0;
                    if (wdt_hit && !ext_rst) begin
                        cause_nxt = 3'(rco_pkg::RCO_C_WDT_RUN);
                        status_nxt[rco_pkg::ST_TO] = 1'b0;
                    end else begin
                        cause_nxt = 3'(rco_pkg::RCO_C_EXT_RUN);
                    end
                end
            end
            rco_pkg::RCO_S_SLEEP: begin
                // wake sources restart through hold; pin wake also reloads option, direction and fsr
                if (ext_rst || wdt_hit || s2_r[2] || s2_r[1]) begin
                    st_nxt = rco_pkg::RCO_S_HOLD;
                    cnt_nxt = 32'h0;
                    pcl_nxt = rco_pkg::PCL_RST;
                    status_nxt[rco_pkg::ST_PD] = 1'b0;
                    status_nxt[5] = 1'b0;
                    if (ext_rst) begin
                        status_nxt[7:4] = 4'h1;
                        cause_nxt = 3'(rco_pkg::RCO_C_EXT_SLP);
                    end else if (wdt_hit) begin
                        status_nxt[7:4] = 4'h0;
                        cause_nxt = 3'(rco_pkg::RCO_C_WDT_SLP);
                    end else if (s2_r[2]) begin
                        status_nxt[7:4] = 4'h9;
                        cause_nxt = 3'(rco_pkg::RCO_C_PIN_WAKE);
                        opt_nxt = rco_pkg::OPT_RST;
                        dir_nxt = rco_pkg::DIR_RST;
                        fsr_nxt = fsr_r | rco_pkg::FSR_SET;
                    end else begin
                        status_nxt[7:4] = 4'h5;
                        cause_nxt = 3'(rco_pkg::RCO_C_CMP_WAKE);
                    end
                end
            end
        endcase
        // software writes while running; a reset in the same cycle wins
        if (wr_go && st_r == rco_pkg::RCO_S_RUN && st_nxt == rco_pkg::RCO_S_RUN) begin
            unique case (idx)
                rco_pkg::IDX_PCL: pcl_nxt = pwdata[7:0];
                rco_pkg::IDX_STATUS: status_nxt[2:0] = pwdata[2:0];
                rco_pkg::IDX_FSR: fsr_nxt = pwdata[7:0];
                rco_pkg::IDX_TRIM: trim_nxt = pwdata[7:0];
                rco_pkg::IDX_CTRL: begin
                    if (pwdata[0]) begin
                        st_nxt = rco_pkg::RCO_S_SLEEP;
                        status_nxt[rco_pkg::ST_PD] = 1'b0;
                        status_nxt[rco_pkg::ST_TO] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= rco_pkg::RCO_S_HOLD;
            cnt_r <= 32'h0;
            por_r <= 1'b1;
            cause_r <= 3'(rco_pkg::RCO_C_POR);
            status_r <= rco_pkg::STATUS_POR;
            fsr_r <= rco_pkg::FSR_SET;
            trim_r <= rco_pkg::TRIM_POR;
            pcl_r <= rco_pkg::PCL_RST;
            opt_r <= rco_pkg::OPT_RST;
            w_r <= 8'h00;
            dir_r <= rco_pkg::DIR_RST;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            por_r <= por_nxt;
            cause_r <= cause_nxt;
            status_r <= status_nxt;
            fsr_r <= fsr_nxt;
            trim_r <= trim_nxt;
            pcl_r <= pcl_nxt;
            opt_r <= opt_nxt;
            w_r <= w_nxt;
            dir_r <= dir_nxt;
        end
    end
    // ----------------------------------------
    // apb read and response, one wait state
    // ----------------------------------------
    // config word has no address here; fuse path only
    always_comb begin
        rdy_nxt = psel & penable & ~rdy_r;
        err_nxt = 1'b0;
        prd_nxt = 32'h0;
        if (psel && penable && !rdy_r) begin
            unique case (idx)
                rco_pkg::IDX_PCL: prd_nxt = {24'h0, pcl_r};
                rco_pkg::IDX_STATUS: prd_nxt = {24'h0, status_r};
                rco_pkg::IDX_FSR: prd_nxt = {24'h0, fsr_r};
                rco_pkg::IDX_TRIM: prd_nxt = {24'h0, trim_r};
                rco_pkg::IDX_CAUSE: prd_nxt = {29'h0, cause_r};
                rco_pkg::IDX_CTRL: prd_nxt = {24'h0, w_r};
                rco_pkg::IDX_CALIB: prd_nxt = {20'h0, calib_word_in};
                default: err_nxt = 1'b1;
            endcase
            if (paddr[11:6] != 6'h0) begin
                err_nxt = 1'b1;
                prd_nxt = 32'h0;
            end
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prd_r <= 32'h0;
            rdy_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            prd_r <= prd_nxt;
            rdy_r <= rdy_nxt;
            err_r <= err_nxt;
        end
    end
    // ----------------------------------------
    // outputs: all registered
    // ----------------------------------------
    logic core_rst_r, slp_r;
    logic [2:0] cfg_out_r;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            core_rst_r <= 1'b1;
            slp_r <= 1'b0;
            cfg_out_r <= 3'h0;
        end else begin
            core_rst_r <= (st_nxt == rco_pkg::RCO_S_HOLD);
            slp_r <= (st_nxt == rco_pkg::RCO_S_SLEEP);
            cfg_out_r <= {cfg_nxt[4], cfg_nxt[3], cfg_nxt[2]};
        end
    end
    // indirect data, timer and port data are outside this block: never reset
    // clock source is fixed; trim is the only knob
    assign prdata = prd_r;
    assign pready = rdy_r;
    assign pslverr = err_r;
    assign core_reset = core_rst_r;
    assign prog_counter = {1'b0, pcl_r};
    assign work_reg = w_r;
    assign osc_trim_reg = trim_r;
    assign option_reg = opt_r;
    assign port_direction = dir_r;
    assign ext_reset_pin_select = cfg_out_r[2];
    assign code_protect_sel = cfg_out_r[1];
    assign watchdog_enable_cfg = cfg_out_r[0];
    assign reset_cause = cause_r;
    assign sleeping = slp_r;
    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_trim_por: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(cfg_ld_r) |-> trim_r == rco_pkg::TRIM_POR)
        else $error("trim not 0xfe after power-on");
    chk_wdt_gate: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r == rco_pkg::RCO_S_RUN && !wdt_en && !ext_rst) |=> st_r != rco_pkg::RCO_S_HOLD)
        else $error("watchdog acted while disabled");
    chk_pin_off: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r == rco_pkg::RCO_S_RUN && !rst_sel && !wdt_hit) |=> st_r != rco_pkg::RCO_S_HOLD)
        else $error("pin reset while not selected");
    chk_cfg_mask: assert property (@(posedge clock) disable iff (!arst_n)
        (cfg_r & ~rco_pkg::CFG_MASK) == 12'h0)
        else $error("unimplemented config bits set");
    chk_ext_slp: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r == rco_pkg::RCO_S_SLEEP && ext_rst) |=> status_r[7:3] == 5'h02)
        else $error("bad status after pin reset in sleep");
    chk_pin_wake: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r == rco_pkg::RCO_S_SLEEP && !ext_rst && !wdt_hit && s2_r[2])
        |=> status_r[7:3] == 5'h12)
        else $error("bad status after pin wake");
    chk_wdt_run: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r == rco_pkg::RCO_S_RUN && wdt_hit && !ext_rst)
        |=> status_r[7:4] == 4'h0 && status_r[3] == $past(status_r[3]))
        else $error("bad status after watchdog reset");
    sequence seq_vec;
        st_r == rco_pkg::RCO_S_VECTOR ##1 st_r == rco_pkg::RCO_S_RUN;
    endsequence
    chk_vector_w: assert property (@(posedge clock) disable iff (!arst_n)
        seq_vec |-> w_r == calib_word_in[7:0] && pcl_r == 8'h00)
        else $error("vector did not load calibration");
    chk_run_rst: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r == rco_pkg::RCO_S_RUN && ext_rst)
        |=> pcl_r == rco_pkg::PCL_RST && opt_r == rco_pkg::OPT_RST && fsr_r[7:5] == 3'h7)
        else $error("reset values not loaded");
    chk_short_dly: assert property (@(posedge clock) disable iff (!arst_n)
        (st_r == rco_pkg::RCO_S_HOLD && !por_r && !ext_rst && cnt_r == 32'h0)
        |-> ##[1:600] st_r == rco_pkg::RCO_S_VECTOR)
        else $error("short start-up delay too long");
endmodule // rco_reset_config

/* File: test/rco_wake_src_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// far side: reset pin and wake sources
// ----------------------------------------
module rco_wake_src_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [2:0] ev_kind, // 1 pin reset, 2 watchdog, 3 pin wake, 4 comparator
    input wire logic ev_go, // one-cycle start of an event
    output logic shared_input_pin,
    output logic pin_change,
    output logic cmp_change,
    output logic watchdog_timeout
);
    logic [3:0] hold_r; // cycles the event still stands
    logic [3:0] hold_nxt;
    logic [2:0] kind_r; // event being shown
    logic [2:0] kind_nxt;
    logic active; // an event is on the lines

    // next state: hold 4 cycles; long enough for the synchroniser,
    // short enough to be gone before the short start-up delay ends
    always_comb begin
        hold_nxt = hold_r;
        kind_nxt = kind_r;
        if (ev_go) begin
            hold_nxt = 4'h4;
            kind_nxt = ev_kind;
        end else if (hold_r != 4'h0) begin
            hold_nxt = hold_r - 4'h1;
        end
    end

    // register only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hold_r <= 4'h0;
            kind_r <= 3'h0;
        end else begin
            hold_r <= hold_nxt;
            kind_r <= kind_nxt;
        end
    end

    assign active = (hold_r != 4'h0);
    // pin has a pull-up: released it idles high, low means reset
    assign shared_input_pin = !(active && kind_r == 3'h1);
    assign watchdog_timeout = active && kind_r == 3'h2;
    assign pin_change = active && kind_r == 3'h3;
    assign cmp_change = active && kind_r == 3'h4;
endmodule // rco_wake_src_model

/* File: test/reset_config_osc_calibration_tb.sv */
`timescale 1ns/10ps
module reset_config_osc_calibration_tb;
    // ----------------------------------------
    // bench state
    // ----------------------------------------
    localparam int POR_T = 50; // shortened start-up counts
    localparam int RST_T = 5;
    logic clock, arst_n, psel, penable, pwrite, pready, pslverr, core_reset, sleeping;
    logic [11:0] cfg_w, calib_w, paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] prog_counter;
    logic [7:0] work_reg, osc_trim_reg, option_reg;
    logic [3:0] port_direction;
    logic [2:0] reset_cause, ev_kind;
    logic wdt_en, cp_sel, pin_sel, ev_go, ext_pin, pin_chg, cmp_chg, wdt_to, err;
    int error_cnt, samples_checked, cyc, hit;
    // status and cause after wakes from sleep: pin reset, watchdog, pin, comparator
    logic [7:0] wake_st [4] = '{8'h15, 8'h05, 8'h95, 8'h55};
    logic [2:0] wake_cause [4] = '{3'h2, 3'h4, 3'h5, 3'h6};

    rco_reset_config #(.POR_CYC(POR_T), .RST_CYC(RST_T)) dut_u (.clock(clock), .arst_n(arst_n),
        .cfg_word_in(cfg_w), .calib_word_in(calib_w), .shared_input_pin(ext_pin),
        .pin_change(pin_chg), .cmp_change(cmp_chg), .watchdog_timeout(wdt_to), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_reset(core_reset),
        .prog_counter(prog_counter), .work_reg(work_reg), .osc_trim_reg(osc_trim_reg),
        .option_reg(option_reg), .port_direction(port_direction),
        .watchdog_enable_cfg(wdt_en), .code_protect_sel(cp_sel),
        .ext_reset_pin_select(pin_sel), .reset_cause(reset_cause), .sleeping(sleeping));
    rco_wake_src_model src_u (.clock(clock), .arst_n(arst_n), .ev_kind(ev_kind), .ev_go(ev_go),
        .shared_input_pin(ext_pin), .pin_change(pin_chg), .cmp_change(cmp_chg),
        .watchdog_timeout(wdt_to));

    // ----------------------------------------
    // clock and tasks
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; reads at an edge see pre-edge values, i.e. what was sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) check("pready", 32'h0, 32'h1);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    // start one far-side event
    task automatic fire(input logic [2:0] k);
        @(posedge clock);
        ev_kind <= k;
        ev_go <= 1'b1;
        @(posedge clock);
        ev_go <= 1'b0;
    endtask

    // wait for the core to be held and then let go; n is the held span
    task automatic wait_boot(output int n);
        int w;
        w = 0;
        n = 0;
        while (core_reset !== 1'b1 && w < 40) begin
            @(posedge clock);
            w++;
        end
        while (core_reset !== 1'b0 && n < 5000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 5000) check("boot", 32'h0, 32'h1);
        @(posedge clock);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        print_verdict();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, ev_go} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ev_kind = 3'h0;
        cfg_w = 12'hff7; // unused bits set on purpose: pin reset, not protected, watchdog on
        calib_w = 12'hc9c;
        error_cnt = 0;
        samples_checked = 0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        wait_boot(cyc);
        check("por delay", 32'(cyc >= POR_T), 32'h1);
        check("pin select", 32'(pin_sel), 32'h1);
        check("protect", 32'(cp_sel), 32'h0);
        check("wdt enable", 32'(wdt_en), 32'h1);
        check("work reg", 32'(work_reg), 32'h9c);
        check("pc", 32'(prog_counter), 32'h0);
        check("option", 32'(option_reg), 32'hff);
        check("direction", 32'(port_direction), 32'hf);
        check("cause", 32'(reset_cause), 32'h0);
        rd_chk("trim", 12'h014, 32'hfe);
        rd_chk("status", 12'h00c, 32'h18);
        apb(1'b0, 12'h010, 32'h0);
        check("fsr top", 32'(rd[7:5]), 32'h7);
        rd_chk("calib", 12'h028, {20'h0, calib_w});
        // no address reaches the configuration word
        apb(1'b0, 12'h030, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        apb(1'b0, 12'h040, 32'h0);
        check("high addr err", 32'(err), 32'h1);
        apb(1'b1, 12'h014, 32'h5a);
        apb(1'b1, 12'h00c, 32'h05);
        apb(1'b1, 12'h010, 32'h0a);
        // pin reset while running: short delay, trim kept, flags as before
        fire(3'h1);
        wait_boot(cyc);
        check("rst delay", 32'(cyc < POR_T), 32'h1);
        check("cause", 32'(reset_cause), 32'h1);
        rd_chk("status", 12'h00c, 32'h1d);
        rd_chk("trim", 12'h014, 32'h5a);
        rd_chk("fsr", 12'h010, 32'hea);
        check("work reg", 32'(work_reg), 32'h9c);
        check("pc", 32'(prog_counter), 32'h0);
        fire(3'h2);
        wait_boot(cyc);
        check("cause", 32'(reset_cause), 32'h3);
        rd_chk("status", 12'h00c, 32'h0d);
        // each wake from sleep; the write made while asleep must be ignored
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h024, 32'h1);
            @(posedge clock);
            check("sleeping", 32'(sleeping), 32'h1);
            apb(1'b1, 12'h014, 32'h33);
            fire(3'(i + 1));
            wait_boot(cyc);
            check("sleeping", 32'(sleeping), 32'h0);
            check("cause", 32'(reset_cause), 32'(wake_cause[i]));
            rd_chk("status", 12'h00c, 32'(wake_st[i]));
            rd_chk("trim", 12'h014, 32'h5a);
        end
        // second power-on: pin is plain input, watchdog off, protection on
        arst_n <= 1'b0;
        cfg_w <= 12'h008;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        wait_boot(cyc);
        check("pin select", 32'(pin_sel), 32'h0);
        check("protect", 32'(cp_sel), 32'h1);
        check("wdt enable", 32'(wdt_en), 32'h0);
        rd_chk("trim", 12'h014, 32'hfe);
        hit = 0;
        fire(3'h1);
        fire(3'h2);
        repeat (30) begin
            @(posedge clock);
            if (core_reset !== 1'b0) hit++;
        end
        check("no reset", 32'(hit), 32'h0);
        print_verdict();
    end
endmodule // reset_config_osc_calibration_tb
